// [hdl/timer8_pkg.sv]
// Shared constants for the 8-bit timer/counter compare unit
package timer8_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [7:0] addr_t;
	typedef logic [31:0] word_t;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam addr_t OFF_CTRL_A = 8'h00;
	localparam addr_t OFF_CTRL_B = 8'h04;
	localparam addr_t OFF_COUNT = 8'h08;
	localparam addr_t OFF_CMP_A = 8'h0C;
	localparam addr_t OFF_CMP_B = 8'h10;
	localparam addr_t OFF_FLAGS = 8'h14;
	localparam addr_t OFF_IRQ_EN = 8'h18;
	localparam addr_t OFF_PORT = 8'h1C;
	// ------------------------------------------------------------
	// Field positions, masks and reset values
	// ------------------------------------------------------------
	localparam int WGM0_BIT = 0;
	localparam int WGM1_BIT = 1;
	localparam int ACT_B_LO = 4;
	localparam int ACT_A_LO = 6;
	localparam int CS_LO = 0;
	localparam int WGM2_BIT = 3;
	localparam int FORCE_B_BIT = 6;
	localparam int FORCE_A_BIT = 7;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_A = 1;
	localparam int FLAG_B = 2;
	localparam int OUT_A_BIT = 0;
	localparam int OUT_B_BIT = 1;
	localparam int DIR_A_BIT = 2;
	localparam int DIR_B_BIT = 3;
	localparam byte_t CTRL_A_MASK = 8'hF3;
	localparam byte_t CTRL_B_MASK = 8'h0F;
	localparam byte_t FLAG_MASK = 8'h07;
	localparam byte_t PORT_MASK = 8'h0F;
	localparam byte_t RST_BYTE = 8'h00;
	localparam logic [23:0] PAD_ZERO = 24'h000000;
	// ------------------------------------------------------------
	// Counter limits, clock sources, modes and actions
	// ------------------------------------------------------------
	localparam byte_t COUNT_MAX = 8'hFF;
	localparam byte_t COUNT_BOTTOM = 8'h00;
	localparam byte_t COUNT_STEP = 8'h01;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_CTC = 3'h2;
	localparam logic [2:0] MODE_FAST = 3'h3;
	localparam logic [2:0] MODE_FAST_TOPA = 3'h7;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
endpackage

// [hdl/timer8_if.sv]
// Carriers between the top module, the counter and the channels
interface count_if;
	logic tick;
	logic clear;
	logic up;
	logic load;
	logic [7:0] load_value;
	logic [7:0] value;
	logic at_max;
	logic at_bottom;
	modport unit(input tick, clear, up, load, load_value,
		output value, at_max, at_bottom);
	modport ctrl(output tick, clear, up, load, load_value,
		input value, at_max, at_bottom);
endinterface

interface channel_if;
	logic tick;
	logic block;
	logic pwm;
	logic reload;
	logic bottom_evt;
	logic cpu_wr;
	logic force_cmp;
	logic [1:0] action;
	logic [7:0] count;
	logic [7:0] wdata;
	logic [7:0] working;
	logic [7:0] readback;
	logic equal;
	logic match;
	logic state;
	modport unit(input tick, block, pwm, reload, bottom_evt, cpu_wr,
		force_cmp, action, count, wdata,
		output working, readback, equal, match, state);
	modport ctrl(output tick, block, pwm, reload, bottom_evt, cpu_wr,
		force_cmp, action, count, wdata,
		input working, readback, equal, match, state);
endinterface

// [hdl/timer8_count_unit.sv]
// 8-bit counter with load, clear and up/down count
module timer8_count_unit (
	input wire logic pclk,
	input wire logic presetn,
	count_if.unit bus
);
	import timer8_pkg::*;

	byte_t value;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= COUNT_BOTTOM;
		end else if (bus.load) begin
			value <= bus.load_value;
		end else if (bus.tick && bus.clear) begin
			value <= COUNT_BOTTOM;
		end else if (bus.tick && bus.up) begin
			value <= value + COUNT_STEP;
		end else if (bus.tick) begin
			value <= value - COUNT_STEP;
		end
	end

	assign bus.value = value;
	assign bus.at_max = (value == COUNT_MAX);
	assign bus.at_bottom = (value == COUNT_BOTTOM);
endmodule // timer8_count_unit

// [hdl/timer8_compare_channel.sv]
// One compare channel: buffered compare value, match and output state
module timer8_compare_channel (
	input wire logic pclk,
	input wire logic presetn,
	channel_if.unit ch
);
	import timer8_pkg::*;

	logic [7:0] buffer;
	logic [7:0] working;
	logic state;

	function automatic logic on_match(input logic st,
		input logic [1:0] act);
		unique case (act)
			ACT_NONE: on_match = st;
			ACT_TOGGLE: on_match = ~st;
			ACT_CLEAR: on_match = 1'b0;
			ACT_SET: on_match = 1'b1;
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer <= COUNT_BOTTOM;
		end else if (ch.cpu_wr) begin
			buffer <= ch.wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			working <= COUNT_BOTTOM;
		end else if (ch.cpu_wr && !ch.pwm) begin
			working <= ch.wdata;
		end else if (ch.pwm && ch.reload) begin
			working <= buffer;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= 1'b0;
		end else if (ch.force_cmp && !ch.pwm) begin
			state <= on_match(state, ch.action);
		end else if (ch.pwm && ch.bottom_evt
			&& ch.action == ACT_CLEAR) begin
			state <= 1'b1;
		end else if (ch.pwm && ch.bottom_evt
			&& ch.action == ACT_SET) begin
			state <= 1'b0;
		end else if (ch.match) begin
			state <= on_match(state, ch.action);
		end
	end

	assign ch.working = working;
	assign ch.state = state;
	assign ch.readback = ch.pwm ? buffer : working;
	assign ch.equal = (ch.count == working);
	assign ch.match = ch.tick & ch.equal & ~ch.block;
endmodule // timer8_compare_channel

// [hdl/timer8_counter_compare_unit.sv]
// 8-bit timer/counter with two compare channels behind an APB slave
//
// Added by the designer: the address map and the APB slave port.
module timer8_counter_compare_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire timer8_pkg::addr_t paddr,
	input wire timer8_pkg::word_t pwdata,
	output timer8_pkg::word_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tick_enable,
	input wire logic [2:0] irq_ack,
	output logic [2:0] irq_request,
	output logic compare_output_a,
	output logic compare_output_a_oe,
	output logic compare_output_b,
	output logic compare_output_b_oe
);
	import timer8_pkg::*;

	// ------------------------------------------------------------
	// Registers and decoded fields
	// ------------------------------------------------------------
	byte_t timer_control_a;
	byte_t timer_control_b;
	byte_t irq_enable;
	byte_t port_ctrl;
	logic [2:0] flags;
	logic [2:0] next_flags;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic block_pending;
	logic [2:0] clock_source_select;
	logic [2:0] waveform_mode_select;
	logic waveform_mode_bit0;
	logic waveform_mode_bit1;
	logic waveform_mode_bit2;
	logic timer_tick;
	logic pwm;
	logic at_top;
	logic overflow_evt;
	logic wrap_evt;
	logic setup;
	logic access_wr;
	logic addr_ok;
	byte_t wbyte;
	byte_t rd_byte;
	logic wr_ctrl_a;
	logic wr_ctrl_b;
	logic wr_count;
	logic wr_cmp_a;
	logic wr_cmp_b;
	logic wr_flags;
	logic wr_irq_en;
	logic wr_port;

	count_if cnt();
	channel_if ch_a();
	channel_if ch_b();

	// mode bits split over two registers
	assign waveform_mode_bit0 = timer_control_a[WGM0_BIT];
	assign waveform_mode_bit1 = timer_control_a[WGM1_BIT];
	assign waveform_mode_bit2 = timer_control_b[WGM2_BIT];
	assign waveform_mode_select = {waveform_mode_bit2,
		waveform_mode_bit1, waveform_mode_bit0};
	assign clock_source_select = timer_control_b[CS_LO +: 3];
	assign pwm = waveform_mode_bit0;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	assign setup = psel & ~penable;
	assign access_wr = psel & penable & pwrite & pready;
	assign wbyte = pwdata[7:0];
	assign wr_ctrl_a = access_wr & (paddr == OFF_CTRL_A);
	assign wr_ctrl_b = access_wr & (paddr == OFF_CTRL_B);
	assign wr_count = access_wr & (paddr == OFF_COUNT);
	assign wr_cmp_a = access_wr & (paddr == OFF_CMP_A);
	assign wr_cmp_b = access_wr & (paddr == OFF_CMP_B);
	assign wr_flags = access_wr & (paddr == OFF_FLAGS);
	assign wr_irq_en = access_wr & (paddr == OFF_IRQ_EN);
	assign wr_port = access_wr & (paddr == OFF_PORT);

	always_comb begin
		addr_ok = 1'b1;
		rd_byte = RST_BYTE;
		unique case (paddr)
			OFF_CTRL_A: rd_byte = timer_control_a;
			OFF_CTRL_B: rd_byte = timer_control_b;
			OFF_COUNT: rd_byte = cnt.value;
			OFF_CMP_A: rd_byte = ch_a.readback;
			OFF_CMP_B: rd_byte = ch_b.readback;
			OFF_FLAGS: rd_byte = {5'h00, flags};
			OFF_IRQ_EN: rd_byte = irq_enable;
			OFF_PORT: rd_byte = port_ctrl;
			default: addr_ok = 1'b0;
		endcase
	end

	// Zero-wait slave: answer in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= {PAD_ZERO, RST_BYTE};
		end else begin
			pready <= setup;
			pslverr <= setup & ~addr_ok;
			if (setup) begin
				prdata <= {PAD_ZERO, rd_byte};
			end
		end
	end

	// Control registers, reserved bits read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_a <= RST_BYTE;
			timer_control_b <= RST_BYTE;
			irq_enable <= RST_BYTE;
			port_ctrl <= RST_BYTE;
		end else begin
			if (wr_ctrl_a) timer_control_a <= wbyte & CTRL_A_MASK;
			if (wr_ctrl_b) timer_control_b <= wbyte & CTRL_B_MASK;
			if (wr_irq_en) irq_enable <= wbyte & FLAG_MASK;
			if (wr_port) port_ctrl <= wbyte & PORT_MASK;
		end
	end

	// ------------------------------------------------------------
	// Tick and counter
	// ------------------------------------------------------------
	// tick gated by clock source
	assign timer_tick = (clock_source_select != CS_STOP) & tick_enable;

	// top is max or compare value A
	assign at_top = (waveform_mode_select == MODE_FAST_TOPA)
		? ch_a.equal : cnt.at_max;

	// clear at top in CTC and fast PWM
	assign wrap_evt = timer_tick & ~wr_count & (pwm ? at_top
		: ((waveform_mode_select == MODE_CTC) & ch_a.equal));

	assign overflow_evt = timer_tick & ~wr_count
		& (pwm ? at_top : cnt.at_max);

	assign cnt.tick = timer_tick;
	assign cnt.clear = wrap_evt;
	assign cnt.up = 1'b1;
	assign cnt.load = wr_count;
	assign cnt.load_value = wbyte;

	timer8_count_unit u_count (
		.pclk(pclk),
		.presetn(presetn),
		.bus(cnt.unit)
	);

	// block matches in the tick after a counter write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_pending <= 1'b0;
		end else if (wr_count) begin
			block_pending <= 1'b1;
		end else if (timer_tick) begin
			block_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Compare channels
	// ------------------------------------------------------------
	assign ch_a.tick = timer_tick;
	assign ch_a.block = block_pending;
	assign ch_a.pwm = pwm;
	assign ch_a.reload = pwm & wrap_evt;
	assign ch_a.bottom_evt = pwm & wrap_evt;
	assign ch_a.cpu_wr = wr_cmp_a;
	assign ch_a.force_cmp = wr_ctrl_b & wbyte[FORCE_A_BIT];
	assign ch_a.action = timer_control_a[ACT_A_LO +: 2];
	assign ch_a.count = cnt.value;
	assign ch_a.wdata = wbyte;

	assign ch_b.tick = timer_tick;
	assign ch_b.block = block_pending;
	assign ch_b.pwm = pwm;
	assign ch_b.reload = pwm & wrap_evt;
	assign ch_b.bottom_evt = pwm & wrap_evt;
	assign ch_b.cpu_wr = wr_cmp_b;
	assign ch_b.force_cmp = wr_ctrl_b & wbyte[FORCE_B_BIT];
	assign ch_b.action = timer_control_a[ACT_B_LO +: 2];
	assign ch_b.count = cnt.value;
	assign ch_b.wdata = wbyte;

	timer8_compare_channel u_chan_a (
		.pclk(pclk),
		.presetn(presetn),
		.ch(ch_a.unit)
	);

	timer8_compare_channel u_chan_b (
		.pclk(pclk),
		.presetn(presetn),
		.ch(ch_b.unit)
	);

	// ------------------------------------------------------------
	// Flags and interrupt requests
	// ------------------------------------------------------------
	// match sets its flag
	assign flag_set = {ch_b.match, ch_a.match, overflow_evt};
	// clear by service or write one
	assign flag_clr = irq_ack | ({3{wr_flags}} & wbyte[2:0]);
	assign next_flags = flag_set | (flags & ~flag_clr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= 3'h0;
			irq_request <= 3'h0;
		end else begin
			flags <= next_flags;
			irq_request <= next_flags & irq_enable[2:0];
		end
	end

	// ------------------------------------------------------------
	// Pin override
	// ------------------------------------------------------------
	// override value, direction from port bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_output_a <= 1'b0;
			compare_output_a_oe <= 1'b0;
			compare_output_b <= 1'b0;
			compare_output_b_oe <= 1'b0;
		end else begin
			compare_output_a <= (ch_a.action != ACT_NONE)
				? ch_a.state : port_ctrl[OUT_A_BIT];
			compare_output_b <= (ch_b.action != ACT_NONE)
				? ch_b.state : port_ctrl[OUT_B_BIT];
			compare_output_a_oe <= port_ctrl[DIR_A_BIT];
			compare_output_b_oe <= port_ctrl[DIR_B_BIT];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_count_write;
		wr_count;
	endsequence

	sequence s_free_tick;
		timer_tick && !wr_count;
	endsequence

	chk_stopped_hold: assert property (
		(clock_source_select == CS_STOP) && !wr_count
		|=> cnt.value == $past(cnt.value))
		else $error("counter moved while stopped");

	chk_write_wins: assert property (
		wr_count |=> cnt.value == $past(wbyte))
		else $error("counter write lost");

	chk_up_count: assert property (
		s_free_tick and !wrap_evt
		|=> cnt.value == $past(cnt.value) + COUNT_STEP)
		else $error("counter did not step up");

	chk_normal_wrap: assert property (
		(waveform_mode_select == MODE_NORMAL) && cnt.at_max
		##0 s_free_tick
		|=> cnt.at_bottom && flags[FLAG_OVF])
		else $error("normal mode wrap or overflow wrong");

	chk_ctc_clear: assert property (
		(waveform_mode_select == MODE_CTC) && ch_a.equal
		##0 s_free_tick |=> cnt.at_bottom)
		else $error("ctc did not clear on match");

	chk_flag_a_set: assert property (
		ch_a.match |=> flags[FLAG_A] ##1 (irq_request[FLAG_A]
		|| !irq_enable[FLAG_A] || !flags[FLAG_A]))
		else $error("match flag a not set");

	chk_flag_service: assert property (
		irq_ack[FLAG_B] && !ch_b.match |=> !flags[FLAG_B])
		else $error("match flag b not cleared");

	chk_block_match: assert property (
		s_count_write ##1 (timer_tick && !wr_count)
		|-> !ch_a.match && !ch_b.match)
		else $error("match not blocked after counter write");

	chk_buffer_hold: assert property (
		pwm && !wrap_evt && $stable(pwm)
		|=> $stable(ch_a.working))
		else $error("working compare changed mid period");

	chk_force_no_flag: assert property (
		ch_a.force_cmp && !ch_a.match && !flags[FLAG_A]
		&& !pwm |=> !flags[FLAG_A])
		else $error("force compare set a flag");

	chk_pin_override: assert property (
		ch_b.action != ACT_NONE |=> compare_output_b == $past(ch_b.state))
		else $error("pin b not overridden");

	chk_pin_direction: assert property (
		1'b1 |=> compare_output_a_oe == $past(port_ctrl[DIR_A_BIT]))
		else $error("pin a enable ignores direction");

	chk_action_none: assert property (
		ch_a.match && ch_a.action == ACT_NONE && !ch_a.bottom_evt
		|=> $stable(ch_a.state))
		else $error("output state changed with no action");
endmodule // timer8_counter_compare_unit

// [sim/timer8_counter_compare_unit_tb_top.sv]
// Self-checking bench for the 8-bit timer/counter compare unit
module timer8_counter_compare_unit_tb_top
	import timer8_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	addr_t paddr;
	word_t pwdata;
	word_t prdata;
	logic pready;
	logic pslverr;
	logic tick_enable;
	logic [2:0] irq_ack;
	logic [2:0] irq_request;
	logic out_a;
	logic oe_a;
	logic out_b;
	logic oe_b;
	int errors;
	int total_checks;
	int seed;
	int ones;
	word_t rv;
	logic perr;
	byte_t start;

	timer8_counter_compare_unit u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.tick_enable(tick_enable),
		.irq_ack(irq_ack),
		.irq_request(irq_request),
		.compare_output_a(out_a),
		.compare_output_a_oe(oe_a),
		.compare_output_b(out_b),
		.compare_output_b_oe(oe_b)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic byte_t exp_count(input byte_t s, input int n);
		return byte_t'(int'(s) + n);
	endfunction

	function automatic word_t exp_wrap(input byte_t s, input int n);
		return ((int'(s) + n) > 255) ? 32'h1 : 32'h0;
	endfunction

	task automatic chk(input word_t got, input word_t exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input addr_t a, input byte_t d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {PAD_ZERO, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input addr_t a, input word_t mask, input word_t exp);
		apb(1'b0, a, RST_BYTE);
		chk(rv & mask, exp);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge pclk);
			tick_enable <= 1'b1;
			@(posedge pclk);
			tick_enable <= 1'b0;
		end
	endtask

	task automatic rticks(input int n, output int cnt);
		bit b;
		cnt = 0;
		repeat (n) begin
			@(posedge pclk);
			b = $random(seed);
			tick_enable <= b;
			cnt += int'(b);
		end
		@(posedge pclk);
		tick_enable <= 1'b0;
	endtask

	task automatic pins(input logic [3:0] exp);
		repeat (2) @(negedge pclk);
		chk({28'h0, out_a, oe_a, out_b, oe_b}, {28'h0, exp});
	endtask

	task automatic conclude;
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 18443;
		errors = 0;
		total_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		tick_enable = 1'b0;
		irq_ack = 3'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 32; a += 4) begin
			rdc(addr_t'(a), 32'hFFFFFFFF, 32'h0);
		end
		pins(4'h0);
		apb(1'b0, 8'h20, RST_BYTE);
		chk({31'h0, perr}, 32'h1);
		chk(rv, 32'h0);
		apb(1'b1, OFF_COUNT, 8'h37);
		rticks(20, ones);
		rdc(OFF_COUNT, 32'hFF, 32'h37);
		apb(1'b1, OFF_CTRL_B, 8'h01);
		for (int i = 0; i < 5; i++) begin
			start = (i == 0) ? 8'hFF : byte_t'($random(seed));
			apb(1'b1, OFF_COUNT, start);
			apb(1'b1, OFF_FLAGS, 8'h07);
			if (i == 0) begin
				ticks(1);
				ones = 1;
			end else begin
				rticks(40, ones);
			end
			rdc(OFF_COUNT, 32'hFF, {24'h0, exp_count(start, ones)});
			rdc(OFF_FLAGS, 32'h1, exp_wrap(start, ones));
		end
		apb(1'b1, OFF_CMP_A, 8'h10);
		apb(1'b1, OFF_CMP_B, 8'h11);
		rdc(OFF_CMP_A, 32'hFF, 32'h10);
		apb(1'b1, OFF_FLAGS, 8'h07);
		apb(1'b1, OFF_COUNT, 8'h10);
		ticks(1);
		rdc(OFF_FLAGS, 32'h7, 32'h0);
		apb(1'b1, OFF_IRQ_EN, 8'h06);
		apb(1'b1, OFF_COUNT, 8'h0F);
		ticks(3);
		rdc(OFF_FLAGS, 32'h7, 32'h6);
		@(negedge pclk);
		chk({29'h0, irq_request}, 32'h6);
		@(posedge pclk);
		irq_ack <= 3'h6;
		@(posedge pclk);
		irq_ack <= 3'h0;
		rdc(OFF_FLAGS, 32'h7, 32'h0);
		apb(1'b1, OFF_COUNT, 8'h0F);
		ticks(3);
		apb(1'b1, OFF_FLAGS, 8'h02);
		rdc(OFF_FLAGS, 32'h7, 32'h4);
		apb(1'b1, OFF_CTRL_A, 8'h42);
		apb(1'b1, OFF_CMP_A, 8'h05);
		apb(1'b1, OFF_COUNT, 8'h00);
		ticks(6);
		rdc(OFF_COUNT, 32'hFF, 32'h0);
		apb(1'b1, OFF_PORT, 8'h04);
		pins(4'hC);
		apb(1'b1, OFF_FLAGS, 8'h07);
		apb(1'b1, OFF_CTRL_B, 8'h81);
		pins(4'h4);
		rdc(OFF_FLAGS, 32'h7, 32'h0);
		rdc(OFF_COUNT, 32'hFF, 32'h0);
		apb(1'b1, OFF_CTRL_A, 8'h02);
		apb(1'b1, OFF_PORT, 8'h05);
		pins(4'hC);
		ticks(6);
		apb(1'b1, OFF_CTRL_A, 8'h82);
		pins(4'h4);
		apb(1'b1, OFF_CTRL_A, 8'hC2);
		ticks(6);
		pins(4'hC);
		apb(1'b1, OFF_CTRL_A, 8'hC3);
		pins(4'hC);
		apb(1'b1, OFF_PORT, 8'h01);
		repeat (2) @(negedge pclk);
		chk({31'h0, oe_a}, 32'h0);
		apb(1'b1, OFF_CTRL_A, 8'h10);
		apb(1'b1, OFF_CTRL_B, 8'h41);
		apb(1'b1, OFF_PORT, 8'h08);
		repeat (2) @(negedge pclk);
		chk({30'h0, out_b, oe_b}, 32'h3);
		apb(1'b1, OFF_CTRL_A, 8'h00);
		apb(1'b1, OFF_CMP_B, 8'h20);
		apb(1'b1, OFF_COUNT, 8'h1E);
		apb(1'b1, OFF_CTRL_A, 8'h03);
		apb(1'b1, OFF_CMP_B, 8'h80);
		rdc(OFF_CMP_B, 32'hFF, 32'h80);
		apb(1'b1, OFF_FLAGS, 8'h07);
		ticks(3);
		rdc(OFF_FLAGS, 32'h4, 32'h4);
		apb(1'b1, OFF_COUNT, 8'hFE);
		ticks(3);
		rdc(OFF_COUNT, 32'hFF, 32'h1);
		apb(1'b1, OFF_FLAGS, 8'h07);
		apb(1'b1, OFF_COUNT, 8'h7E);
		ticks(3);
		rdc(OFF_FLAGS, 32'h4, 32'h4);
		apb(1'b1, OFF_CTRL_A, 8'h00);
		apb(1'b1, OFF_CMP_A, 8'h03);
		apb(1'b1, OFF_COUNT, 8'h00);
		apb(1'b1, OFF_CTRL_B, 8'h09);
		apb(1'b1, OFF_CTRL_A, 8'h03);
		apb(1'b1, OFF_CMP_A, 8'h03);
		apb(1'b1, OFF_FLAGS, 8'h07);
		ticks(6);
		rdc(OFF_COUNT, 32'hFF, 32'h2);
		rdc(OFF_FLAGS, 32'h1, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, OFF_CTRL_A, 8'hF0);
		apb(1'b1, OFF_PORT, 8'h0C);
		pins(4'h5);
		conclude();
	end

	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		conclude();
	end
endmodule // timer8_counter_compare_unit_tb_top
